// ==== lpr_map.svh ====
// Register map, field positions and reset values of the link
// diagnostics and PHY register access bank.
// Assumes 32-bit APB data with one register per aligned word.
`ifndef LPR_MAP_SVH
`define LPR_MAP_SVH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define LPR_ADDR_W 8
`define LPR_DIAG_OFS 8'h18
`define LPR_PHYA_OFS 8'h20

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LPR_DIAG_RST 32'h4000_0000
`define LPR_PHYA_RST 32'h0000_0000

// ----------------------------------------
// Diagnostics fields (word bit 0 is the least significant bit)
// ----------------------------------------
`define LPR_DIAG_SLOW_ACK 30
`define LPR_DIAG_CNT_EN 29
`define LPR_DIAG_TEST_ACC 27
`define LPR_DIAG_AGT_WR 26
`define LPR_DIAG_RDY_HI 24
`define LPR_DIAG_RDY_LO 21
`define LPR_DIAG_MGMT_ACK 17
`define LPR_DIAG_CNT_HI 13
`define LPR_DIAG_CNT_LO 8

// ----------------------------------------
// PHY access fields
// ----------------------------------------
`define LPR_PHYA_RD 31
`define LPR_PHYA_WR 30
`define LPR_PHYA_TADR_HI 27
`define LPR_PHYA_TADR_LO 24
`define LPR_PHYA_WBYTE_HI 23
`define LPR_PHYA_WBYTE_LO 16
`define LPR_PHYA_RADR_HI 11
`define LPR_PHYA_RADR_LO 8
`define LPR_PHYA_RBYTE_HI 7
`define LPR_PHYA_RBYTE_LO 0

`endif

// ==== lpr_phy_model.sv ====
// PHY register file model on the far side of the bank.
// Assumes the bank's valid/ready request handshake.
`timescale 1ns/1ps
`default_nettype none
module lpr_phy_model
(
	// Clock, reset and pace
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [1:0] lag,
	// Request and status
	input wire logic phy_req_valid,
	output logic phy_req_ready,
	input wire lpr_pkg::lpr_phy_req_t phy_req,
	output logic phy_stat_valid,
	output lpr_pkg::lpr_phy_stat_t phy_stat
);
	import lpr_pkg::*;
	logic [7:0] mem [16];
	logic [1:0] wait_reg;
	assign phy_req_ready = phy_req_valid && wait_reg == lag;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wait_reg <= 2'h0;
			phy_stat_valid <= 1'b0;
			phy_stat <= '0;
			for (int i = 0; i < 16; i++)
				mem[i] <= 8'h00;
		end
		else
		begin
			wait_reg <= (phy_req_ready || !phy_req_valid) ? 2'h0 : wait_reg + 2'h1;
			// Idle status lines toggle so a stale value never matches
			phy_stat_valid <= phy_req_ready && !phy_req.is_write;
			if (phy_req_ready && !phy_req.is_write)
				phy_stat <= {phy_req.addr, mem[phy_req.addr]};
			else
				phy_stat <= ~phy_stat;
			if (phy_req_ready && phy_req.is_write)
				mem[phy_req.addr] <= phy_req.data;
		end
	end
endmodule
`default_nettype wire

// ==== lpr_pkg.sv ====
// Types shared by the link diagnostics and PHY register access bank.
// Assumes the field widths of the register map header.
`default_nettype none
package lpr_pkg;

	// ----------------------------------------
	// PHY request and status carriers
	// ----------------------------------------
	typedef struct packed {
		logic is_write;
		logic [3:0] addr;
		logic [7:0] data;
	} lpr_phy_req_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] data;
	} lpr_phy_stat_t;

	typedef enum logic {
		LPR_ISSUE_READ,
		LPR_ISSUE_WRITE
	} lpr_req_kind_t;

endpackage
`default_nettype wire

// ==== lpr_regs.sv ====
// Link diagnostics register and PHY register access register, reached over APB.
// Assumes one clock, synchronous link inputs, and a PHY port that accepts a
// request on phy_req_valid and phy_req_ready both high at a rising edge.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "lpr_map.svh"

module lpr_regs
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`LPR_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Link events
	input wire logic bus_reset,
	input wire logic [3:0] agent_valid,
	input wire logic allowance_tick,
	input wire logic mirror_wr,
	input wire logic mirror_val,
	// Link controls
	output logic slow_ack_select,
	output logic test_register_access,
	output logic agent_state_write_access,
	output logic mgmt_conflict_ack_enable,
	output logic [5:0] allowance_count,
	output logic [3:0] cmd_agent_ready,
	// PHY register port
	output logic phy_req_valid,
	input wire logic phy_req_ready,
	output lpr_pkg::lpr_phy_req_t phy_req,
	input wire logic phy_stat_valid,
	input wire lpr_pkg::lpr_phy_stat_t phy_stat
);
	import lpr_pkg::*;

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic slow_ack_reg;
	logic cnt_en_reg;
	logic test_acc_reg;
	logic agt_wr_reg;
	logic mgmt_ack_reg;
	logic [3:0] ready_reg;
	logic [5:0] cnt_reg;
	logic [5:0] cnt_next;
	logic rd_req_reg;
	logic wr_req_reg;
	logic [3:0] tadr_reg;
	logic [7:0] wbyte_reg;
	logic [3:0] radr_reg;
	logic [7:0] rbyte_reg;
	logic [31:0] prdata_reg;
	logic [31:0] diag_word;
	logic [31:0] phya_word;
	lpr_req_kind_t kind;
	localparam logic [31:0] diag_rst_val = `LPR_DIAG_RST;
	logic setup;
	logic access;
	logic hit_diag;
	logic hit_phya;
	logic wr_diag;
	logic wr_phya;
	logic sent;

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	// Zero wait states; read data is captured in the setup cycle so that it
	// leaves a flip-flop during the access cycle.
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign hit_diag = (paddr == `LPR_DIAG_OFS);
	assign hit_phya = (paddr == `LPR_PHYA_OFS);
	assign wr_diag = access && pwrite && hit_diag;
	assign wr_phya = access && pwrite && hit_phya;
	assign pready = 1'b1;
	assign pslverr = access && !hit_diag && !hit_phya;
	assign prdata = prdata_reg;

	// Byte strobes gate a write lane by lane
	function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
			begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction

	logic [31:0] diag_wval;
	logic [31:0] phya_wval;
	assign diag_wval = lane_merge(diag_word, pwdata, pstrb);
	assign phya_wval = lane_merge(phya_word, pwdata, pstrb);

	// ----------------------------------------
	// Readback words
	// ----------------------------------------
	always_comb
	begin
		diag_word = 32'h0000_0000;
		phya_word = 32'h0000_0000;
		diag_word[`LPR_DIAG_SLOW_ACK] = slow_ack_reg;
		diag_word[`LPR_DIAG_CNT_EN] = cnt_en_reg;
		diag_word[`LPR_DIAG_TEST_ACC] = test_acc_reg;
		diag_word[`LPR_DIAG_AGT_WR] = agt_wr_reg;
		// Agent 0 sits at the highest of the four positions
		diag_word[`LPR_DIAG_RDY_HI:`LPR_DIAG_RDY_LO] =
			{ready_reg[0], ready_reg[1], ready_reg[2], ready_reg[3]};
		diag_word[`LPR_DIAG_MGMT_ACK] = mgmt_ack_reg;
		diag_word[`LPR_DIAG_CNT_HI:`LPR_DIAG_CNT_LO] = cnt_reg;
		phya_word[`LPR_PHYA_RD] = rd_req_reg;
		phya_word[`LPR_PHYA_WR] = wr_req_reg;
		phya_word[`LPR_PHYA_TADR_HI:`LPR_PHYA_TADR_LO] = tadr_reg;
		phya_word[`LPR_PHYA_WBYTE_HI:`LPR_PHYA_WBYTE_LO] = wbyte_reg;
		phya_word[`LPR_PHYA_RADR_HI:`LPR_PHYA_RADR_LO] = radr_reg;
		phya_word[`LPR_PHYA_RBYTE_HI:`LPR_PHYA_RBYTE_LO] = rbyte_reg;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_reg <= 32'h0000_0000;
		end
		else if (setup && !pwrite)
		begin
			if (hit_diag)
			begin
				prdata_reg <= diag_word;
			end
			else if (hit_phya)
			begin
				prdata_reg <= phya_word;
			end
			else
			begin
				prdata_reg <= 32'h0000_0000;
			end
		end
	end

	// ----------------------------------------
	// Diagnostics control bits
	// ----------------------------------------
	// Reset value, bus reset leaves these alone
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			slow_ack_reg <= diag_rst_val[`LPR_DIAG_SLOW_ACK];
			cnt_en_reg <= 1'b0;
			test_acc_reg <= 1'b0;
			agt_wr_reg <= 1'b0;
		end
		else if (wr_diag)
		begin
			slow_ack_reg <= diag_wval[`LPR_DIAG_SLOW_ACK];
			cnt_en_reg <= diag_wval[`LPR_DIAG_CNT_EN];
			test_acc_reg <= diag_wval[`LPR_DIAG_TEST_ACC];
			agt_wr_reg <= diag_wval[`LPR_DIAG_AGT_WR];
		end
	end

	// One shared bit; this port wins when the 08h side writes in the same cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mgmt_ack_reg <= 1'b0;
		end
		else if (wr_diag)
		begin
			mgmt_ack_reg <= diag_wval[`LPR_DIAG_MGMT_ACK];
		end
		else if (mirror_wr)
		begin
			mgmt_ack_reg <= mirror_val;
		end
	end

	// Ready follows agent validity, bus reset forces zero
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ready_reg <= 4'h0;
		end
		else if (bus_reset)
		begin
			ready_reg <= 4'h0;
		end
		else
		begin
			ready_reg <= agent_valid;
		end
	end

	// ----------------------------------------
	// Allowance counter
	// ----------------------------------------
	// Held at zero while disabled so that a new enable starts a fresh count
	always_comb
	begin
		cnt_next = cnt_reg;
		if (!cnt_en_reg)
		begin
			cnt_next = 6'h00;
		end
		else if (allowance_tick)
		begin
			cnt_next = cnt_reg + 6'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_reg <= 6'h00;
		end
		else
		begin
			cnt_reg <= cnt_next;
		end
	end

	// ----------------------------------------
	// PHY access register
	// ----------------------------------------
	// Zero reset, no bus reset term
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tadr_reg <= 4'h0;
			wbyte_reg <= 8'h00;
		end
		else if (wr_phya)
		begin
			tadr_reg <= phya_wval[`LPR_PHYA_TADR_HI:`LPR_PHYA_TADR_LO];
			wbyte_reg <= phya_wval[`LPR_PHYA_WBYTE_HI:`LPR_PHYA_WBYTE_LO];
		end
	end

	// Read goes first when both bits are pending
	assign kind = rd_req_reg ? LPR_ISSUE_READ : LPR_ISSUE_WRITE;
	assign phy_req_valid = rd_req_reg || wr_req_reg;
	assign sent = phy_req_valid && phy_req_ready;

	always_comb
	begin
		phy_req.addr = tadr_reg;
		phy_req.data = wbyte_reg;
		unique case (kind)
			LPR_ISSUE_READ:
			begin
				phy_req.is_write = 1'b0;
				phy_req.data = 8'h00;
			end
			LPR_ISSUE_WRITE:
			begin
				phy_req.is_write = 1'b1;
			end
		endcase
	end

	// A software set in the cycle the request leaves stays pending
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rd_req_reg <= 1'b0;
		end
		// Set by write, cleared when sent
		else if (wr_phya && phya_wval[`LPR_PHYA_RD])
		begin
			rd_req_reg <= 1'b1;
		end
		else if (sent && kind == LPR_ISSUE_READ)
		begin
			rd_req_reg <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wr_req_reg <= 1'b0;
		end
		// Set by write, cleared when sent
		else if (wr_phya && phya_wval[`LPR_PHYA_WR])
		begin
			wr_req_reg <= 1'b1;
		end
		else if (sent && kind == LPR_ISSUE_WRITE)
		begin
			wr_req_reg <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			radr_reg <= 4'h0;
			rbyte_reg <= 8'h00;
		end
		else if (phy_stat_valid)
		begin
			radr_reg <= phy_stat.addr;
			rbyte_reg <= phy_stat.data;
		end
	end

	// ----------------------------------------
	// Link control outputs
	// ----------------------------------------
	// Tardy versus busy choice
	assign slow_ack_select = slow_ack_reg;
	assign test_register_access = test_acc_reg;
	assign agent_state_write_access = agt_wr_reg;
	assign mgmt_conflict_ack_enable = mgmt_ack_reg;
	assign allowance_count = cnt_reg;
	assign cmd_agent_ready = ready_reg;

endmodule
`default_nettype wire

// ==== lpr_regs_assertions.sv ====
// Checker of the diagnostics and PHY access bank.
// Assumes it is bound to lpr_regs and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module lpr_regs_chk
(
	// Bus
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	// Link
	input wire logic bus_reset,
	input wire logic [3:0] agent_valid,
	input wire logic mirror_wr,
	input wire logic mirror_val,
	input wire logic slow_ack_select,
	input wire logic test_register_access,
	input wire logic mgmt_conflict_ack_enable,
	input wire logic [5:0] allowance_count,
	input wire logic [3:0] cmd_agent_ready,
	// PHY
	input wire logic phy_req_valid,
	input wire logic phy_req_ready,
	input wire lpr_pkg::lpr_phy_req_t phy_req
);
	import lpr_pkg::*;
	logic acc_wr;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	assign acc_wr = psel && penable && pwrite;
	sequence wr_s(a);
		acc_wr && paddr == a && pstrb[3];
	endsequence
	sequence rd_s;
		psel && !penable && !pwrite && paddr == 8'h18;
	endsequence
	diag_wr_a: assert property (
		wr_s(8'h18) |=> slow_ack_select == $past(pwdata[30])
		&& test_register_access == $past(pwdata[27])) else $error("diag write lost");
	rdy_clear_a: assert property (
		bus_reset |=> cmd_agent_ready == 4'h0) else $error("ready kept on bus reset");
	rdy_copy_a: assert property (
		!bus_reset |=> cmd_agent_ready == $past(agent_valid)) else $error("ready wrong");
	cnt_read_a: assert property (
		rd_s |=> prdata[13:8] == $past(allowance_count)
		&& prdata[30] == $past(slow_ack_select)) else $error("diag read wrong");
	rdy_order_a: assert property (
		rd_s |=> prdata[24] == $past(cmd_agent_ready[0])
		&& prdata[21] == $past(cmd_agent_ready[3])) else $error("ready bit order");
	mirror_copy_a: assert property (
		mirror_wr && !(acc_wr && paddr == 8'h18) |=> mgmt_conflict_ack_enable
		== $past(mirror_val)) else $error("mirror lost");
	req_hold_a: assert property (
		phy_req_valid && !phy_req_ready |=> phy_req_valid && $stable(phy_req))
		else $error("request dropped");
	rd_issue_a: assert property (
		wr_s(8'h20) ##0 pwdata[31] && !phy_req_valid |=> phy_req_valid
		&& !phy_req.is_write && phy_req.addr == $past(pwdata[27:24]))
		else $error("read not issued");
	wr_issue_a: assert property (
		wr_s(8'h20) ##0 pwdata[30] && !pwdata[31] && pstrb[2] && !phy_req_valid
		|=> phy_req.is_write && phy_req_valid && phy_req.data == $past(pwdata[23:16]))
		else $error("write not issued");
	req_clear_a: assert property (
		phy_req_valid && phy_req_ready && !acc_wr |=> !phy_req_valid
		|| (phy_req.is_write && !$past(phy_req.is_write))) else $error("bit not cleared");
endmodule
bind lpr_regs lpr_regs_chk lpr_regs_chk_inst (.*);
`default_nettype wire

// ==== tb_link_diag_and_phy_reg_access.sv ====
// Self-checking bench of the diagnostics and PHY access bank.
// Assumes a zero-wait APB slave and the PHY model beside it.
`timescale 1ns/1ps
`default_nettype none
module tb_link_diag_and_phy_reg_access;
	import lpr_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, se;
	logic bus_reset = 0, tick = 0, mirror_wr = 0, mirror_val = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [3:0] agent_valid = 0, rdy;
	logic [1:0] lag = 0;
	logic pready, pslverr, sas, tra, asw, mca, rv, rr, sv;
	logic [5:0] cnt;
	lpr_phy_req_t req;
	lpr_phy_stat_t st;
	int err_count = 0, num_checks = 0;
	lpr_regs lpr_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .bus_reset(bus_reset), .agent_valid(agent_valid),
		.allowance_tick(tick), .mirror_wr(mirror_wr), .mirror_val(mirror_val),
		.slow_ack_select(sas), .test_register_access(tra), .agent_state_write_access(asw),
		.mgmt_conflict_ack_enable(mca), .allowance_count(cnt), .cmd_agent_ready(rdy),
		.phy_req_valid(rv), .phy_req_ready(rr), .phy_req(req), .phy_stat_valid(sv),
		.phy_stat(st));
	lpr_phy_model lpr_phy_model_inst (.pclk(pclk), .presetn(presetn), .lag(lag),
		.phy_req_valid(rv), .phy_req_ready(rr), .phy_req(req), .phy_stat_valid(sv),
		.phy_stat(st));
	initial
	begin
		forever #2 pclk = ~pclk;
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	// One whole APB transfer; entered and left just after a rising edge
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic t_reset();
		apb(8'h20, 0, 0);
		chk(rd, 32'h0000_0000);
		$display("reset done");
	endtask
	task automatic pulse_ticks();
		tick <= 1'b1;
		repeat (3) @(posedge pclk);
		tick <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic t_diag();
		apb(8'h18, 0, 0);
		chk(rd, 32'h4000_0000);
		// Test access, agent write, count enable and mgmt ack set, cleared again by the next write
		apb(8'h18, 1, 32'h2DE2_3F00);
		chk({sas, tra, asw, mca}, 4'b0111);
		pulse_ticks();
		apb(8'h18, 0, 0);
		chk(rd, 32'h2C02_0300);
		apb(8'h18, 1, 32'h4000_0000);
		pulse_ticks();
		apb(8'h18, 0, 0);
		chk(rd, 32'h4000_0000);
		chk(sas, 1'b1);
		$display("diag done");
	endtask
	task automatic t_agents();
		agent_valid <= 4'b0101;
		repeat (2) @(posedge pclk);
		apb(8'h18, 0, 0);
		chk(rd, 32'h4140_0000);
		bus_reset <= 1'b1;
		@(posedge pclk);
		bus_reset <= 1'b0;
		@(posedge pclk);
		chk(rdy, 4'h0);
		mirror_wr <= 1'b1;
		mirror_val <= 1'b1;
		@(posedge pclk);
		mirror_wr <= 1'b0;
		apb(8'h18, 0, 0);
		chk(rd, 32'h4142_0000);
		agent_valid <= 4'h0;
		apb(8'h1C, 0, 0);
		chk(se, 1'b1);
		chk(rd, 32'h0000_0000);
		$display("agents done");
	endtask
	task automatic phy_op(input logic [31:0] d, input logic [31:0] exp);
		int n;
		n = 0;
		apb(8'h20, 1, d);
		do
		begin
			apb(8'h20, 0, 0);
			n++;
		end
		while (rd[31:30] !== 2'b00 && n < 10);
		chk(rd[31:30], 2'b00);
		apb(8'h20, 0, 0);
		chk(rd, exp);
	endtask
	task automatic t_phy(input logic [1:0] l, input logic [7:0] b, input logic [7:0] old,
		input logic [15:0] ret);
		lag <= l;
		phy_op(32'h45A5_0000, {16'h05A5, ret});
		phy_op(32'h8500_0000, 32'h0500_05A5);
		phy_op({16'hC900 | b, 16'h0000}, {16'h0900 | b, 16'h0900 | old});
		phy_op(32'h8900_0000, {24'h0900_09, b});
		bus_reset <= 1'b1;
		@(posedge pclk);
		bus_reset <= 1'b0;
		apb(8'h20, 0, 0);
		chk(rd, {24'h0900_09, b});
		$display("phy pass done");
	endtask
	initial
	begin
		#20000;
		err_count++;
		summarize();
	end
	initial
	begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_diag();
		t_agents();
		t_phy(2'd0, 8'h3C, 8'h00, 16'h0000);
		t_phy(2'd3, 8'hC3, 8'h3C, 16'h093C);
		summarize();
	end
endmodule
`default_nettype wire
